/* src/cache_pkg.sv */
// Shared constants and carrier types for the four-way cache arrays.
// Assumes a single 20 MHz core clock and a word-wide register port.
package cache_pkg;

	////////////////////////////////////////////////////////////////
	// Geometry
	localparam int WAYS = 4;
	localparam int SETS = 256;
	localparam int LINE_W = 128;
	localparam int TAG_W = 22;
	localparam int LRU_W = 6;
	localparam int IDX_W = 8;
	localparam int IDX_HI = 11;
	localparam int IDX_LO = 4;
	localparam int WORD_HI = 3;
	localparam int WORD_LO = 2;
	localparam int SHADOW_W = 3;

	////////////////////////////////////////////////////////////////
	// Register addresses
	localparam logic [31:0] CTL_ADDR = 32'hffffffec;
	localparam logic [31:0] LOCK_ADDR = 32'h040000b0;
	localparam logic [31:0] LOCK_ALIAS_ADDR = 32'ha40000b0;
	localparam logic [31:0] LRU_SEL_ADDR = 32'hffffffe0;
	localparam logic [31:0] LRU_DATA_ADDR = 32'hffffffe4;

	// Reset values
	localparam logic [2:0] CTL_RESET = 3'h0;
	localparam logic [3:0] LOCK_RESET = 4'h0;

	// Control field positions
	localparam int EN_BIT = 0;
	localparam int WTHRU_BIT = 1;
	localparam int WBACK_BIT = 2;
	localparam int FLUSH_ALL_BIT = 3;

	// Lock field positions
	localparam int W2_LOCK_BIT = 0;
	localparam int W2_LOAD_BIT = 1;
	localparam int W3_LOCK_BIT = 8;
	localparam int W3_LOAD_BIT = 9;

	// History bit p orders way PAIR_LO[p] against PAIR_HI[p]; 1 = low older
	localparam logic [1:0] PAIR_LO [LRU_W] = '{2'h2, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0};
	localparam logic [1:0] PAIR_HI [LRU_W] = '{2'h3, 2'h3, 2'h2, 2'h3, 2'h2, 2'h1};

	////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [2:0]
	{
		OP_NONE = 3'b000,
		OP_READ = 3'b001,
		OP_WRITE = 3'b010,
		OP_FILL = 3'b011,
		OP_PREFETCH = 3'b100
	} op_kind_t;

	typedef enum logic [1:0]
	{
		user_region_zero = 2'b00,
		privileged_region_zero = 2'b01,
		privileged_region_one = 2'b10,
		privileged_region_three = 2'b11
	} region_t;

	typedef struct packed
	{
		op_kind_t kind;
		logic [31:0] addr;
		logic [TAG_W-1:0] ptag;
		region_t region;
		logic [31:0] wdata;
		logic [LINE_W-1:0] line;
	} req_t;

	typedef struct packed
	{
		logic done;
		logic hit;
		logic [1:0] way;
		logic [31:0] rdata;
		logic victim_dirty;
		logic [TAG_W-1:0] victim_tag;
		logic [LINE_W-1:0] victim_line;
		logic write_back;
		logic stored;
	} rsp_t;

endpackage : cache_pkg

/* src/lru_victim_select.sv */
// Replacement choice and most-recent update for one set's history.
// Assumes the history holds a legal ordering of the four ways.
`timescale 1ns/1ns
module lru_victim_select
(
	input wire logic [5:0] lru,
	input wire logic [3:0] locked,
	input wire logic [1:0] acc_way,
	output logic [1:0] victim,
	output logic [5:0] nxt_lru
);
	import cache_pkg::*;

	logic [WAYS-1:0] oldest;

	////////////////////////////////////////////////////////////////
	// A way is the victim when older than every unlocked way
	generate
		for (genvar w = 0; w < WAYS; w++)
		begin : g_old
			always_comb
			begin
				oldest[w] = !locked[w];
				for (int p = 0; p < LRU_W; p++)
				begin
					if (PAIR_LO[p] == 2'(w) && !locked[PAIR_HI[p]] && !lru[p])
						oldest[w] = 1'b0;
					if (PAIR_HI[p] == 2'(w) && !locked[PAIR_LO[p]] && lru[p])
						oldest[w] = 1'b0;
				end
			end
		end
	endgenerate

	always_comb
	begin
		victim = 2'h0;
		for (int w = WAYS - 1; w >= 0; w--)
		begin
			if (oldest[w])
				victim = 2'(w);
		end
	end

	// Accessed way becomes newer than all; ordering stays legal
	always_comb
	begin
		nxt_lru = lru;
		for (int p = 0; p < LRU_W; p++)
		begin
			if (acc_way == PAIR_LO[p])
				nxt_lru[p] = 1'b0;
			else if (acc_way == PAIR_HI[p])
				nxt_lru[p] = 1'b1;
		end
	end

endmodule : lru_victim_select

/* src/four_way_unified_cache_arrays.sv */
// Tag, data, flag and history arrays of the 16 KB four-way cache,
// with its control and lock registers.
// Assumes the core presents one operation per cycle, already translated,
// and that the bus controller performs fills and write-backs.
//
// Contract
// - Four ways, 256 lines of 16 bytes
// - Valid flag per entry
// - Dirty flag set by write-back writes
// - Store 22-bit physical tag, bits 31..10
// - Replacement zeroes top three tag bits
// - Power-on clears flags, manual reset keeps
// - Tags and data never reset
// - Fill only whole 16-byte lines
// - Set index from address bits 11..4
// - Six history bits per set
// - Victim way 3 or 2 by history
// - Victim way 1 or 0 by history
// - Power-on clears history, manual reset keeps
// - Ways 2 and 3 lockable only
// - Per-region write-back or write-through
// - Hit needs tag match and valid
// - Flush clears flags and history, reads 0
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ns
module four_way_unified_cache_arrays
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic manual_rst_n,
	input wire logic dsp_mode,
	input wire cache_pkg::req_t req,
	output cache_pkg::rsp_t rsp,
	input wire logic [31:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata
);
	import cache_pkg::*;

	logic [2:0] ctl_ff;
	logic [3:0] lock_ff;
	logic [IDX_W-1:0] lru_sel_ff;
	logic [LRU_W-1:0] lru_ff [SETS];
	logic [31:0] rdata_ff;
	rsp_t rsp_ff;
	rsp_t nxt_rsp;

	logic [WAYS-1:0] way_hit;
	logic [WAYS-1:0] way_valid;
	logic [WAYS-1:0] way_dirty;
	logic [WAYS-1:0] fill_we;
	logic [WAYS-1:0] word_we;
	logic [TAG_W-1:0] way_tag [WAYS];
	logic [LINE_W-1:0] way_line [WAYS];
	logic [1:0] hit_way;
	logic [1:0] victim_way;
	logic [LRU_W-1:0] nxt_lru;

	////////////////////////////////////////////////////////////////
	// Register decode
	wire live = rst_n && manual_rst_n;
	wire sel_ctl = (reg_addr == CTL_ADDR);
	wire sel_lock = (reg_addr == LOCK_ADDR) || (reg_addr == LOCK_ALIAS_ADDR);
	wire sel_lru_idx = (reg_addr == LRU_SEL_ADDR);
	wire sel_lru = (reg_addr == LRU_DATA_ADDR);
	wire flush = live && reg_wr && sel_ctl && reg_wdata[FLUSH_ALL_BIT];
	wire sw_lru_we = live && reg_wr && sel_lru;
	wire cache_on = ctl_ff[EN_BIT];

	// Lock register reads back nothing useful, so it reads zero
	wire [31:0] nxt_rdata =
		!reg_rd ? 32'h0 :
		sel_ctl ? {29'h0, ctl_ff} :
		sel_lru_idx ? {24'h0, lru_sel_ff} :
		sel_lru ? {26'h0, lru_ff[lru_sel_ff]} :
		32'h0;

	////////////////////////////////////////////////////////////////
	// Request decode
	// Set index bits
	wire [IDX_W-1:0] idx = req.addr[IDX_HI:IDX_LO];
	wire [1:0] word = req.addr[WORD_HI:WORD_LO];
	wire [TAG_W-1:0] cmp_tag =
		{{SHADOW_W{1'b0}}, req.ptag[TAG_W-SHADOW_W-1:0]};
	// Flush and manual reset both hold off core operations
	wire op_go = live && !flush && cache_on;
	wire is_rd = op_go && (req.kind == OP_READ);
	wire is_wr = op_go && (req.kind == OP_WRITE);
	wire is_fill = op_go && (req.kind == OP_FILL);
	wire is_pf = op_go && (req.kind == OP_PREFETCH);
	wire any_hit = |way_hit;

	// P1 follows the write-back bit, others the write-through bit
	wire wb_mode = (req.region == privileged_region_one) ?
		ctl_ff[WBACK_BIT] : !ctl_ff[WTHRU_BIT];

	// Locks only on ways 2 and 3, only in DSP mode
	wire lock2 = dsp_mode && lock_ff[0];
	wire lock3 = dsp_mode && lock_ff[2];
	wire [3:0] lock_mask = {lock3, lock2, 2'b00};
	wire force3 = is_pf && lock3 && lock_ff[3];
	wire force2 = is_pf && lock2 && lock_ff[1];
	wire [1:0] fill_way = force3 ? 2'h3 : force2 ? 2'h2 : victim_way;

	// Prefetch that hits does nothing
	wire do_fill = is_fill || (is_pf && !any_hit);
	wire do_word = is_wr && any_hit;
	wire [1:0] acc_way = do_fill ? fill_way : hit_way;
	wire hw_lru_we = do_fill || ((is_rd || is_wr) && any_hit);
	wire [LRU_W-1:0] lru_cur = lru_ff[idx];

	////////////////////////////////////////////////////////////////
	// Control and lock registers
	always_ff @(posedge ref_clk)
	begin
		if (!live)
		begin
			ctl_ff <= CTL_RESET;
			lock_ff <= LOCK_RESET;
			lru_sel_ff <= '0;
		end
		else if (reg_wr)
		begin
			if (sel_ctl)
				ctl_ff <= reg_wdata[2:0];
			if (sel_lock)
				lock_ff <= {reg_wdata[W3_LOAD_BIT], reg_wdata[W3_LOCK_BIT],
					reg_wdata[W2_LOAD_BIT], reg_wdata[W2_LOCK_BIT]};
			if (sel_lru_idx)
				lru_sel_ff <= reg_wdata[IDX_W-1:0];
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
			rdata_ff <= 32'h0;
		else
			rdata_ff <= nxt_rdata;
	end

	////////////////////////////////////////////////////////////////
	// Per-way arrays
	// Four ways of 256 lines
	generate
		for (genvar w = 0; w < WAYS; w++)
		begin : g_way
			logic [TAG_W-1:0] tag_mem [SETS];
			logic [LINE_W-1:0] data_mem [SETS];
			logic [SETS-1:0] valid_ff;
			logic [SETS-1:0] dirty_ff;

			assign way_hit[w] = valid_ff[idx] && (tag_mem[idx] == cmp_tag);
			assign way_valid[w] = valid_ff[idx];
			assign way_dirty[w] = dirty_ff[idx];
			assign way_tag[w] = tag_mem[idx];
			assign way_line[w] = data_mem[idx];
			assign fill_we[w] = do_fill && (fill_way == 2'(w));
			assign word_we[w] = do_word && (hit_way == 2'(w));

			always_ff @(posedge ref_clk)
			begin
				if (!rst_n || flush)
					valid_ff <= '0;
				else if (fill_we[w])
					valid_ff[idx] <= 1'b1;
			end

			always_ff @(posedge ref_clk)
			begin
				if (!rst_n || flush)
					dirty_ff <= '0;
				else if (fill_we[w])
					dirty_ff[idx] <= 1'b0;
				else if (word_we[w] && wb_mode)
					dirty_ff[idx] <= 1'b1;
			end

			// No reset on tags or data
			always_ff @(posedge ref_clk)
			begin
				if (fill_we[w])
				begin
					tag_mem[idx] <= cmp_tag;
					data_mem[idx] <= req.line;
				end
				else if (word_we[w])
					data_mem[idx][{word, 5'h0} +: 32] <= req.wdata;
			end
		end
	endgenerate

	always_comb
	begin
		hit_way = 2'h0;
		for (int w = WAYS - 1; w >= 0; w--)
		begin
			if (way_hit[w])
				hit_way = 2'(w);
		end
	end

	////////////////////////////////////////////////////////////////
	// Replacement history
	// Victim from history
	lru_victim_select u_victim
	(
		.lru(lru_cur),
		.locked(lock_mask),
		.acc_way(acc_way),
		.victim(victim_way),
		.nxt_lru(nxt_lru)
	);

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n || flush)
		begin
			for (int i = 0; i < SETS; i++)
				lru_ff[i] <= '0;
		end
		else
		begin
			if (hw_lru_we)
				lru_ff[idx] <= nxt_lru;
			// Software pattern taken as written; it wins
			if (sw_lru_we)
				lru_ff[lru_sel_ff] <= reg_wdata[LRU_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////
	// Response, one cycle after the request
	always_comb
	begin
		nxt_rsp = '0;
		nxt_rsp.done = live && (req.kind != OP_NONE);
		nxt_rsp.hit = any_hit && (is_rd || is_wr || is_pf);
		nxt_rsp.way = nxt_rsp.hit ? hit_way : fill_way;
		nxt_rsp.rdata = way_line[hit_way][{word, 5'h0} +: 32];
		// Victim fields tell the bus side what a fill would evict
		nxt_rsp.victim_dirty = way_valid[fill_way] && way_dirty[fill_way];
		nxt_rsp.victim_tag = way_tag[fill_way];
		nxt_rsp.victim_line = way_line[fill_way];
		nxt_rsp.write_back = wb_mode;
		nxt_rsp.stored = (|fill_we) || (|word_we);
	end

	always_ff @(posedge ref_clk)
	begin
		if (!live)
			rsp_ff <= '0;
		else
			rsp_ff <= nxt_rsp;
	end

	assign rsp = rsp_ff;
	assign reg_rdata = rdata_ff;

endmodule : four_way_unified_cache_arrays

/* bench/cache_arrays_props.sv */
// Port assertions for the four-way cache arrays.
// Bound onto the design top; one clock, rst_n is power-on reset.
`timescale 1ns/1ns
module cache_arrays_props
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic manual_rst_n,
	input wire cache_pkg::req_t req,
	input wire cache_pkg::rsp_t rsp,
	input wire logic [31:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata
);
	import cache_pkg::*;
	logic [2:0] ctl_ff;
	wire ctl_wr = reg_wr && reg_addr == CTL_ADDR;
	wire live = manual_rst_n && req.kind != OP_NONE && !ctl_wr;
	wire pol = req.region == privileged_region_one ? ctl_ff[2] : !ctl_ff[1];
	wire lock_rd = reg_addr == LOCK_ADDR || reg_addr == LOCK_ALIAS_ADDR;
	// Flush bit is a command, so it is never kept
	always_ff @(posedge ref_clk)
	begin
		if (!rst_n || !manual_rst_n)
			ctl_ff <= CTL_RESET;
		else if (ctl_wr)
			ctl_ff <= reg_wdata[2:0];
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence s_flush;
		ctl_wr && reg_wdata[FLUSH_ALL_BIT] ##1
			!(req.kind inside {OP_FILL, OP_PREFETCH});
	endsequence
	sequence s_lookup;
		manual_rst_n && req.kind == OP_READ;
	endsequence
	a_done_taken: assert property (live |=> rsp.done)
		else $error("no done after request");
	a_no_idle_done: assert property (req.kind == OP_NONE |=> !rsp.done)
		else $error("done without request");
	a_flush_misses: assert property (s_flush ##1 s_lookup |=> !rsp.hit)
		else $error("hit after flush");
	a_off_idle: assert property (live && !ctl_ff[EN_BIT] |=>
		!rsp.hit && !rsp.stored) else $error("disabled cache acted");
	a_fill_whole: assert property (live && ctl_ff[EN_BIT] &&
		req.kind == OP_FILL |=> rsp.stored) else $error("fill not stored");
	a_wmiss_no_store: assert property (rsp.done && !rsp.hit &&
		$past(req.kind) == OP_WRITE |-> !rsp.stored)
		else $error("write miss stored");
	a_policy_flag: assert property (live && ctl_ff[EN_BIT] |=>
		rsp.write_back == $past(pol)) else $error("wrong write policy");
	a_ctl_readback: assert property (reg_rd && manual_rst_n &&
		reg_addr == CTL_ADDR |=> reg_rdata == {29'h0, ctl_ff})
		else $error("control readback wrong");
	a_lock_hidden: assert property (reg_rd && lock_rd |=>
		reg_rdata == 32'h0) else $error("lock register readable");
endmodule : cache_arrays_props
bind four_way_unified_cache_arrays cache_arrays_props props
(
	.ref_clk(ref_clk), .rst_n(rst_n), .manual_rst_n(manual_rst_n),
	.req(req), .rsp(rsp), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata)
);

/* bench/mem_model.sv */
// Memory behind the bus controller, answering line fetches.
// Assumes one fetch outstanding; lat sets the answer delay.
`timescale 1ns/1ns
module mem_model
(
	input wire logic ref_clk,
	input wire logic fetch,
	input wire logic [31:0] addr,
	input wire logic [3:0] lat,
	output logic ready,
	output logic [127:0] line
);
	logic busy_ff = 1'b0;
	logic [3:0] wait_ff;
	logic [31:0] addr_ff;
	always @(posedge ref_clk)
	begin
		ready <= 1'b0;
		// Released data wanders so stale use shows up
		line <= {4{$urandom}};
		if (fetch)
		begin
			busy_ff <= 1'b1;
			wait_ff <= lat;
			addr_ff <= addr;
		end
		else if (busy_ff && wait_ff != 4'h0)
			wait_ff <= wait_ff - 4'h1;
		else if (busy_ff)
		begin
			busy_ff <= 1'b0;
			ready <= 1'b1;
			line <= {addr_ff ^ 32'h3, addr_ff ^ 32'h2, addr_ff ^ 32'h1, addr_ff};
		end
	end
endmodule : mem_model

/* bench/tb.sv */
// Self-checking bench for the four-way cache arrays.
// Drives core port and registers; mem_model supplies fill lines.
`timescale 1ns/1ns
module tb;
	import cache_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic manual_rst_n = 1'b1;
	logic [31:0] reg_addr = 32'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	req_t req = '0;
	rsp_t rsp;
	logic fetch = 1'b0;
	logic [31:0] maddr = 32'h0;
	logic [3:0] lat = 4'h0;
	logic ready;
	logic [127:0] mline;
	logic rd_d = 1'b0;
	rsp_t eq[$];
	rsp_t mq[$];
	logic [31:0] rq[$];
	logic [31:0] a[5];
	logic [31:0] ed = 32'h0;
	logic [21:0] vt = 22'h0;
	logic [127:0] ln = 128'h0;
	logic [7:0] s;
	logic vc = 1'b0, vd = 1'b0, wc = 1'b0, wb = 1'b0;
	logic wm = 1'b0;
	logic [1:0] ew = 2'h0;
	logic dsp_mode = 1'b0;
	region_t rg = privileged_region_zero;
	int err_total = 0;
	int compares = 0;
	always #25 ref_clk = ~ref_clk;
	four_way_unified_cache_arrays dut
	(
		.ref_clk(ref_clk), .rst_n(rst_n), .manual_rst_n(manual_rst_n),
		.dsp_mode(dsp_mode), .req(req), .rsp(rsp), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata)
	);
	mem_model mem
	(
		.ref_clk(ref_clk), .fetch(fetch), .addr(maddr), .lat(lat),
		.ready(ready), .line(mline)
	);
	task automatic chk(string nm, logic [188:0] seen, logic [188:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_total++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic test_done;
		$display("compares %0d mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done
	task automatic wr(logic [31:0] ad, logic [31:0] d);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
	endtask : wr
	task automatic rd(logic [31:0] ad, logic [31:0] e);
		rq.push_back(e);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(posedge ref_clk);
	endtask : rd
	// Fields are compared only where the mask is set
	task automatic op(op_kind_t k, logic [31:0] ad, logic h, logic st);
		rsp_t e;
		rsp_t m;
		e = '{1'b1, h, ew, ed, vd, vt, 128'h0, wb, st};
		m = '{1'b1, k != OP_FILL, {2{wm}}, {32{k == OP_READ && h}}, vc,
			{22{vc}}, 128'h0, wc, 1'b1};
		eq.push_back(e);
		mq.push_back(m);
		req <= '{k, ad, ad[31:10], rg, ed, ln};
		@(posedge ref_clk);
		req.kind <= OP_NONE;
		@(posedge ref_clk);
		{vc, wc, wm} = 3'h0;
	endtask : op
	task automatic load(logic [31:0] ad, logic [1:0] w);
		int n;
		op(OP_READ, ad, 1'b0, 1'b0);
		fetch <= 1'b1;
		maddr <= {ad[31:4], 4'h0};
		lat <= 4'($urandom_range(0, 9));
		@(posedge ref_clk);
		fetch <= 1'b0;
		n = 0;
		while (!ready && n < 40)
		begin
			@(posedge ref_clk);
			n++;
		end
		ln = mline;
		{wm, ew} = {1'b1, w};
		op(OP_FILL, ad, 1'b0, 1'b1);
	endtask : load
	always @(posedge ref_clk)
	begin
		if (rd_d)
			chk("reg_rdata", reg_rdata, rq.pop_front());
		if (rsp.done)
		begin
			chk("rsp", rsp & mq[0], eq[0] & mq[0]);
			void'(eq.pop_front());
			void'(mq.pop_front());
		end
		rd_d <= reg_rd;
	end
	initial
	begin
		repeat (3000) @(posedge ref_clk);
		err_total++;
		test_done();
	end
	////////////////////////////////////////////////////////////////
	initial
	begin
		void'($urandom(51611));
		s = 8'($urandom);
		for (int i = 0; i < 5; i++)
		begin
			a[i] = $urandom;
			a[i][14:4] = {3'(i), s};
		end
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		rd(CTL_ADDR, 32'h0);
		rd(LOCK_ALIAS_ADDR, 32'h0);
		rd(32'hffffffe8, 32'h0);
		wr(LOCK_ADDR, 32'h0);
		op(OP_READ, a[0], 1'b0, 1'b0);
		wr(CTL_ADDR, 32'h9);
		rd(CTL_ADDR, 32'h1);
		wr(LRU_SEL_ADDR, {24'h0, ~s});
		wr(LRU_DATA_ADDR, 32'h38);
		rd(LRU_DATA_ADDR, 32'h38);
		$display("registers done");
		for (int i = 0; i < 4; i++)
			load(a[i], 2'(3 - i));
		// Word n of a fetched line holds its address xor n
		ed = {a[0][31:4], 2'h0, a[0][3:2]};
		op(OP_READ, a[0], 1'b1, 1'b0);
		ed = $urandom;
		op(OP_WRITE, a[0], 1'b1, 1'b1);
		op(OP_READ, a[0], 1'b1, 1'b0);
		{vc, vt, vd} = {1'b1, 3'h0, a[1][28:10], 1'b0};
		{wm, ew} = 3'h6;
		op(OP_READ, a[4], 1'b0, 1'b0);
		for (int i = 1; i < 4; i++)
		begin
			ed = {a[i][31:4], 2'h0, a[i][3:2]};
			op(OP_READ, a[i], 1'b1, 1'b0);
		end
		{vc, vt, vd} = {1'b1, 3'h0, a[0][28:10], 1'b1};
		{wm, ew} = 3'h7;
		op(OP_READ, a[4], 1'b0, 1'b0);
		op(OP_WRITE, a[4], 1'b0, 1'b0);
		$display("replacement done");
		manual_rst_n <= 1'b0;
		@(posedge ref_clk);
		manual_rst_n <= 1'b1;
		@(posedge ref_clk);
		rd(CTL_ADDR, 32'h0);
		wr(CTL_ADDR, 32'h1);
		ed = {a[1][31:4], 2'h0, a[1][3:2]};
		for (int r = 0; r < 4; r++)
		begin
			rg = region_t'(r);
			{wc, wb} = {1'b1, r != 2};
			op(OP_READ, a[1], 1'b1, 1'b0);
		end
		op(OP_PREFETCH, a[1], 1'b1, 1'b0);
		wr(CTL_ADDR, 32'h9);
		op(OP_READ, a[1], 1'b0, 1'b0);
		load(a[2], 2'h3);
		rst_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		wr(CTL_ADDR, 32'h1);
		op(OP_READ, a[2], 1'b0, 1'b0);
		rd(LRU_DATA_ADDR, 32'h0);
		$display("resets done");
		// Way 2 lock and load steers a prefetch miss away from way 3
		wr(LOCK_ALIAS_ADDR, 32'h3);
		dsp_mode <= 1'b1;
		{wm, ew} = 3'h6;
		op(OP_PREFETCH, a[2], 1'b0, 1'b1);
		ed = {a[2][31:4], 2'h0, a[2][3:2]};
		{wm, ew} = 3'h6;
		op(OP_READ, a[2], 1'b1, 1'b0);
		$display("locks done");
		@(posedge ref_clk);
		chk("pending", 189'(eq.size()), 189'h0);
		test_done();
	end
endmodule : tb
